// *** core/wakeup_pkg.sv ***
package wakeup_pkg;

    // Clock and timing
    localparam int CLK_HZ            = 40_000_000;
    localparam int HOLD_TIME_US      = 1000;
    localparam int HOLD_CYCLES       = HOLD_TIME_US * (CLK_HZ / 1_000_000);
    localparam int EE_TYP_TIME_MS    = 150;
    localparam int EE_TIMEOUT_MS     = 600;
    localparam int EE_TIMEOUT_CYCLES = EE_TIMEOUT_MS * (CLK_HZ / 1000);

    // Pins and subsystems
    localparam int NUM_GPIO     = 7;
    localparam int SEL_PIN_IDX  = 6;
    localparam int NUM_SLAVES   = 9;
    localparam int BANK_DEPTH   = 256;

    // Serial map of the master page
    localparam logic [7:0] PAGE_REG_ADDR = 8'hFF;
    localparam logic [7:0] MASTER_PAGE   = 8'h00;
    localparam logic [7:0] PAGE_RESET    = 8'h00;
    localparam logic [7:0] LAST_INDEX    = 8'hFF;

    // Settings layout (byte address, bit position)
    localparam logic [7:0] SET_LOCK_ADDR   = 8'h00;
    localparam int         LOCK_LSB        = 0;
    localparam int         MANUAL_N_BIT    = 2;
    localparam logic [7:0] SET_EE_DIS_ADDR = 8'h01;
    localparam logic [7:0] SET_SER_ADDR    = 8'h02;
    localparam int         SER_I2C_BIT     = 0;
    localparam logic [7:0] SET_GPIO_ADDR   = 8'h03;
    localparam logic [1:0] LOCK_PAT_A      = 2'h2;
    localparam logic [1:0] LOCK_PAT_B      = 2'h1;
    localparam logic [7:0] GPIO_MODE_RESET = 8'h00;

    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_COPY_LIVE,
        CMD_PROCEED,
        CMD_LOCK_STORE,
        CMD_ESCAPE
    } cmd_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ser_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } ee_word_t;

    typedef struct packed {
        logic done;
        logic hdr_ok;
        logic crc_ok;
    } ee_result_t;

endpackage : wakeup_pkg

// *** core/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                meta[i]     <= 1'b0;
                sync_out[i] <= 1'b0;
            end else begin
                meta[i]     <= async_in[i];
                sync_out[i] <= meta[i];
            end
        end
    end

endmodule : pin_sync

// *** core/wakeup_controller.sv ***
`timescale 1ns/1ps
module wakeup_controller
    import wakeup_pkg::*;
#(
    parameter int HOLD_CYC   = HOLD_CYCLES,
    parameter int EE_TMO_CYC = EE_TIMEOUT_CYCLES
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    input  wire logic [NUM_GPIO-1:0]   gpio_pin,
    output logic                       gpio_hold,
    output logic      [7:0]            gpio_mode,
    output logic      [7:0]            otp_addr,
    input  wire logic [7:0]            otp_data,
    output logic                       otp_prog,
    output logic      [1:0]            otp_lock_val,
    input  wire ser_req_t              ser_req,
    output logic      [7:0]            ser_rdata,
    output logic      [7:0]            ser_page,
    output logic                       ser_i2c,
    output logic                       ser_slave_en,
    output logic                       ee_search,
    input  wire ee_word_t              ee_word,
    input  wire ee_result_t            ee_res,
    output logic                       ee_read_done,
    output logic                       ee_error,
    input  wire logic                  cmd_valid,
    input  wire cmd_t                  cmd_code,
    output logic                       cmd_accept,
    output logic                       cmd_reject,
    output logic                       xo_enable,
    output logic      [NUM_SLAVES-1:0] slave_rst_n,
    output logic                       master_active,
    output logic                       prg_wait
);

    typedef enum logic [3:0] {
        ST_OTP_LOAD,
        ST_LIVE_COPY,
        ST_DECODE,
        ST_EE_SEARCH,
        ST_EE_COPY,
        ST_DECIDE,
        ST_XO_EN,
        ST_SLAVE_REL,
        ST_ACTIVE,
        ST_PRG_WAIT
    } state_t;

    state_t               st;
    logic [7:0]           idx;
    logic [3:0]           rel_idx;
    logic                 boot_done;
    logic [NUM_GPIO-1:0]  pin_s;
    logic [NUM_GPIO-1:0]  pin_latch;
    logic [1:0]           cap_cnt;
    logic [15:0]          hold_cnt;
    logic [24:0]          ee_tmo;
    logic [7:0]           shadow [BANK_DEPTH];
    logic [7:0]           live   [BANK_DEPTH];
    logic                 locked;
    logic                 ee_allowed;
    logic                 ee_fail;
    logic                 ser_hit;

    pin_sync #(
        .WIDTH (NUM_GPIO)
    ) u_pin_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in (gpio_pin),
        .sync_out (pin_s)
    );

    // Both accepted lock patterns count; the manual bit is active low
    assign locked = (live[SET_LOCK_ADDR][LOCK_LSB +: 2] == LOCK_PAT_A ||
                     live[SET_LOCK_ADDR][LOCK_LSB +: 2] == LOCK_PAT_B) &&
                    live[SET_LOCK_ADDR][MANUAL_N_BIT];
    // Any latched pin 0 to 5 enabled by the mask disables the EEPROM search
    assign ee_allowed = ~|(pin_latch[NUM_GPIO-2:0] & live[SET_EE_DIS_ADDR][NUM_GPIO-2:0]);
    assign ee_fail    = ee_res.done ? !(ee_res.hdr_ok && ee_res.crc_ok)
                                    : (ee_tmo == 25'(EE_TMO_CYC - 1));
    assign ser_hit    = ser_slave_en && ser_req.valid;
    assign ee_search     = (st == ST_EE_SEARCH);
    assign master_active = (st == ST_ACTIVE);
    assign prg_wait      = (st == ST_PRG_WAIT);
    assign otp_addr      = idx;

    // Pins settle through the synchroniser before the capture
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_cnt   <= 2'h0;
            pin_latch <= '0;
        end else if (cap_cnt != 2'h3) begin
            cap_cnt <= cap_cnt + 2'h1;
            if (cap_cnt == 2'h2) begin
                pin_latch <= pin_s;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_cnt  <= 16'h0;
            gpio_hold <= 1'b1;
        end else if (gpio_hold) begin
            hold_cnt <= hold_cnt + 16'h1;
            if (hold_cnt == 16'(HOLD_CYC - 1)) begin
                gpio_hold <= 1'b0;
            end
        end
    end

    // No reset on the banks: contents are defined by the boot copy
    always_ff @(posedge sys_clk) begin
        if (st == ST_OTP_LOAD) begin
            shadow[idx] <= otp_data;
        end else if (st == ST_EE_SEARCH && ee_word.valid) begin
            shadow[ee_word.addr] <= ee_word.data;
        end else if (ser_hit && ser_req.write && ser_page == MASTER_PAGE &&
                     ser_req.addr != PAGE_REG_ADDR) begin
            shadow[ser_req.addr] <= ser_req.wdata;
        end
    end

    // Live settings have a single writer: the controller's own copy
    always_ff @(posedge sys_clk) begin
        if (st == ST_LIVE_COPY || st == ST_EE_COPY) begin
            live[idx] <= shadow[idx];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ser_page  <= PAGE_RESET;
            ser_rdata <= 8'h00;
        end else if (ser_hit) begin
            if (ser_req.addr == PAGE_REG_ADDR) begin
                ser_rdata <= ser_page;
                if (ser_req.write) begin
                    ser_page <= ser_req.wdata;
                end
            end else if (ser_page == MASTER_PAGE) begin
                ser_rdata <= shadow[ser_req.addr];
            end else begin
                ser_rdata <= 8'h00;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ee_tmo <= 25'h0;
        end else if (st == ST_EE_SEARCH) begin
            ee_tmo <= ee_tmo + 25'h1;
        end else begin
            ee_tmo <= 25'h0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st        <= ST_OTP_LOAD;
            idx       <= 8'h00;
            rel_idx   <= 4'h0;
            boot_done <= 1'b0;
        end else begin
            unique case (st)
                ST_OTP_LOAD: begin
                    idx <= idx + 8'h1;
                    if (idx == LAST_INDEX) begin
                        st <= ST_LIVE_COPY;
                    end
                end
                ST_LIVE_COPY: begin
                    idx <= idx + 8'h1;
                    if (idx == LAST_INDEX) begin
                        st <= boot_done ? ST_PRG_WAIT : ST_DECODE;
                    end
                end
                ST_DECODE: begin
                    // Wait out the pin capture before reading the latch
                    if (cap_cnt == 2'h3) begin
                        boot_done <= 1'b1;
                        if (ee_allowed && pin_latch[SEL_PIN_IDX]) begin
                            st <= ST_EE_SEARCH;
                        end else begin
                            st <= ST_DECIDE;
                        end
                    end
                end
                ST_EE_SEARCH: begin
                    if (ee_fail) begin
                        st <= ST_PRG_WAIT;
                    end else if (ee_res.done) begin
                        st <= ST_EE_COPY;
                    end
                end
                ST_EE_COPY: begin
                    idx <= idx + 8'h1;
                    if (idx == LAST_INDEX) begin
                        st <= ST_DECIDE;
                    end
                end
                ST_DECIDE: begin
                    st <= locked ? ST_XO_EN : ST_PRG_WAIT;
                end
                ST_XO_EN: begin
                    st <= ST_SLAVE_REL;
                end
                ST_SLAVE_REL: begin
                    rel_idx <= rel_idx + 4'h1;
                    if (rel_idx == 4'(NUM_SLAVES - 1)) begin
                        st <= ST_ACTIVE;
                    end
                end
                ST_ACTIVE: begin
                    if (cmd_valid && cmd_code == CMD_ESCAPE) begin
                        st <= ST_PRG_WAIT;
                    end
                end
                ST_PRG_WAIT: begin
                    if (cmd_valid && cmd_code == CMD_COPY_LIVE) begin
                        st <= ST_LIVE_COPY;
                    end else if (cmd_valid && cmd_code == CMD_PROCEED) begin
                        st <= ST_ACTIVE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_accept   <= 1'b0;
            cmd_reject   <= 1'b0;
            otp_prog     <= 1'b0;
            otp_lock_val <= 2'h0;
        end else begin
            cmd_accept <= cmd_valid && cmd_code != CMD_NONE &&
                          ((st == ST_PRG_WAIT && cmd_code != CMD_ESCAPE) ||
                           (st == ST_ACTIVE && cmd_code == CMD_ESCAPE));
            cmd_reject <= cmd_valid && cmd_code != CMD_NONE &&
                          !((st == ST_PRG_WAIT && cmd_code != CMD_ESCAPE) ||
                            (st == ST_ACTIVE && cmd_code == CMD_ESCAPE));
            otp_prog   <= cmd_valid && cmd_code == CMD_LOCK_STORE &&
                          st == ST_PRG_WAIT;
            if (cmd_valid && cmd_code == CMD_LOCK_STORE && st == ST_PRG_WAIT) begin
                otp_lock_val <= LOCK_PAT_A;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ee_read_done <= 1'b0;
            ee_error     <= 1'b0;
            ser_i2c      <= 1'b0;
            ser_slave_en <= 1'b0;
        end else begin
            if (st == ST_DECODE && cap_cnt == 2'h3) begin
                ser_i2c <= pin_latch[SEL_PIN_IDX];
                if (!(ee_allowed && pin_latch[SEL_PIN_IDX])) begin
                    ee_read_done <= 1'b1;
                    ser_slave_en <= 1'b1;
                end
            end
            if (st == ST_EE_SEARCH && ee_fail) begin
                ee_error     <= 1'b1;
                ee_read_done <= 1'b1;
                ser_slave_en <= 1'b1;
            end
            if (st == ST_EE_COPY && idx == LAST_INDEX) begin
                ee_read_done <= 1'b1;
                ser_i2c      <= shadow[SET_SER_ADDR][SER_I2C_BIT];
                ser_slave_en <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            gpio_mode   <= GPIO_MODE_RESET;
            xo_enable   <= 1'b0;
            slave_rst_n <= '0;
        end else begin
            if ((st == ST_LIVE_COPY || st == ST_EE_COPY) && idx == LAST_INDEX) begin
                gpio_mode <= shadow[SET_GPIO_ADDR];
            end
            if (st == ST_XO_EN || (st == ST_PRG_WAIT && cmd_valid &&
                                   cmd_code == CMD_PROCEED)) begin
                xo_enable <= 1'b1;
            end
            if (st == ST_SLAVE_REL) begin
                slave_rst_n[rel_idx] <= 1'b1;
            end
            // Manual wake frees the slaves so the host can program each page
            if (st == ST_PRG_WAIT && cmd_valid && cmd_code == CMD_PROCEED) begin
                slave_rst_n <= '1;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    lock_store_gate_a: assert property (
        otp_prog |-> $past(st) == ST_PRG_WAIT && $past(cmd_code) == CMD_LOCK_STORE)
        else $error("lock store outside wait state");
    misplaced_cmd_a: assert property (
        cmd_valid && st != ST_PRG_WAIT &&
        (cmd_code == CMD_COPY_LIVE || cmd_code == CMD_PROCEED) |=> cmd_reject && !cmd_accept)
        else $error("misplaced directive not rejected");
    done_sticky_a: assert property (
        ee_read_done |=> ee_read_done [*8])
        else $error("read done dropped");
    error_path_a: assert property (
        $rose(ee_error) |-> ee_read_done && st == ST_PRG_WAIT)
        else $error("error without done or wait");
    slaves_held_a: assert property (
        !boot_done || st == ST_EE_SEARCH || st == ST_EE_COPY |-> slave_rst_n == '0)
        else $error("slave released during boot");
    // A manual proceed frees every slave at the edge that enables the oscillator
    xo_before_slave_a: assert property (
        $rose(slave_rst_n[0]) |-> xo_enable &&
            ($past(st, 2) == ST_XO_EN || $past(st) == ST_PRG_WAIT))
        else $error("slave released before oscillator");
    hold_length_a: assert property (
        $fell(gpio_hold) |-> $past(hold_cnt) == 16'(HOLD_CYC - 1))
        else $error("pin hold length wrong");
    no_slave_search_a: assert property (
        ee_search |-> !ser_slave_en)
        else $error("serial slave active during search");
    unlocked_wait_a: assert property (
        st == ST_DECIDE && !locked |=> st == ST_PRG_WAIT ##1 !xo_enable)
        else $error("unlocked wake did not stop");

    auto_wake_c: cover property (st == ST_SLAVE_REL ##[1:20] st == ST_ACTIVE);
    ee_fail_c: cover property ($rose(ee_error));
    escape_c: cover property (st == ST_ACTIVE ##1 st == ST_PRG_WAIT);

endmodule : wakeup_controller

// *** tb/wake_partner.sv ***
`timescale 1ns/1ps
module wake_partner
    import wakeup_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic [7:0] otp_addr,
    output logic      [7:0] otp_data,
    input  wire logic       ee_search,
    output ee_word_t        ee_word,
    output ee_result_t      ee_res,
    input  wire logic [7:0] lock_byte,
    input  wire logic [7:0] dis_byte,
    input  wire logic [1:0] ee_mode
);
    // Store content is combinational; filler bytes differ so a wrong index shows
    always_comb begin
        case (otp_addr)
            8'h00:   otp_data = lock_byte;
            8'h01:   otp_data = dis_byte;
            8'h02:   otp_data = 8'h00;
            8'h03:   otp_data = 8'h3C;
            default: otp_data = otp_addr ^ 8'hA5;
        endcase
    end
    // Mode 0 good block, 1 bad CRC, 2 silent so the loader has to time out
    initial begin
        ee_word = '0;
        ee_res  = '0;
        forever begin
            @(posedge ee_search);
            if (ee_mode != 2'h2) begin
                repeat (4) @(negedge sys_clk);
                ee_word = '{1'b1, 8'h00, 8'h00};
                @(negedge sys_clk);
                ee_word = '{1'b1, 8'h03, 8'hA5};
                @(negedge sys_clk);
                ee_word = '0;
                ee_res  = '{1'b1, 1'b1, (ee_mode == 2'h0)};
                @(negedge sys_clk);
                ee_res = '0;
                repeat (2) @(negedge sys_clk);
                // A late word after the search must be dropped
                ee_word = '{1'b1, 8'h04, 8'hEE};
                @(negedge sys_clk);
                ee_word = '0;
            end
        end
    end
endmodule : wake_partner

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import wakeup_pkg::*;
    localparam int HOLD = 20;
    logic            sys_clk, rst_n, gpio_hold, otp_prog, ser_i2c, ser_slave_en, ee_search;
    logic            ee_read_done, ee_error, cmd_valid, cmd_accept, cmd_reject;
    logic            xo_enable, master_active, prg_wait, order_bad;
    logic [6:0]      gpio_pin;
    logic [7:0]      gpio_mode, otp_addr, otp_data, ser_rdata, ser_page, lock_byte, dis_byte, q;
    logic [1:0]      otp_lock_val, ee_mode, prog_val;
    logic [8:0]      slave_rst_n;
    ser_req_t        ser_req;
    ee_word_t        ee_word;
    ee_result_t      ee_res;
    cmd_t            cmd_code;
    int              bad_count, checked, cycles, acc_cnt, rej_cnt, prog_cnt, srch_cnt, s0;
    logic [7:0]      lk_tab [5] = '{8'h06, 8'h05, 8'h02, 8'h07, 8'h04};
    logic            act_tab [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

    wakeup_controller #(.HOLD_CYC(HOLD), .EE_TMO_CYC(200)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .gpio_pin(gpio_pin), .gpio_hold(gpio_hold),
        .gpio_mode(gpio_mode), .otp_addr(otp_addr), .otp_data(otp_data), .otp_prog(otp_prog),
        .otp_lock_val(otp_lock_val), .ser_req(ser_req), .ser_rdata(ser_rdata),
        .ser_page(ser_page), .ser_i2c(ser_i2c), .ser_slave_en(ser_slave_en),
        .ee_search(ee_search), .ee_word(ee_word), .ee_res(ee_res),
        .ee_read_done(ee_read_done), .ee_error(ee_error), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_accept(cmd_accept), .cmd_reject(cmd_reject),
        .xo_enable(xo_enable), .slave_rst_n(slave_rst_n), .master_active(master_active),
        .prg_wait(prg_wait));
    wake_partner partner (
        .sys_clk(sys_clk), .otp_addr(otp_addr), .otp_data(otp_data), .ee_search(ee_search),
        .ee_word(ee_word), .ee_res(ee_res), .lock_byte(lock_byte), .dis_byte(dis_byte),
        .ee_mode(ee_mode));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic finish_test();
        $display("mismatches %0d, comparisons %0d", bad_count, checked);
        if (bad_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Slave resets must only ever open as a thermometer, never while the oscillator is off
    always @(posedge sys_clk) begin
        if (rst_n && slave_rst_n != 9'h000 && xo_enable !== 1'b1) order_bad <= 1'b1;
        if (rst_n && (slave_rst_n & (slave_rst_n + 9'h001)) != 9'h000) order_bad <= 1'b1;
        if (cmd_accept === 1'b1) acc_cnt <= acc_cnt + 1;
        if (cmd_reject === 1'b1) rej_cnt <= rej_cnt + 1;
        if (otp_prog === 1'b1) prog_cnt <= prog_cnt + 1;
        if (otp_prog === 1'b1) prog_val <= otp_lock_val;
        if (ee_search === 1'b1) srch_cnt <= srch_cnt + 1;
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            bad_count++;
            finish_test();
        end
    end

    // Serial access only after boot, so the search window is never disturbed
    task automatic boot(input logic [7:0] lk, input logic [7:0] ds, input logic [6:0] pins,
                        input logic [1:0] md);
        int n;
        rst_n     = 1'b0;
        lock_byte = lk;
        dis_byte  = ds;
        gpio_pin  = pins;
        ee_mode   = md;
        repeat (8) @(negedge sys_clk);
        check({gpio_hold, 6'h00, slave_rst_n}, 16'h8000);
        order_bad = 1'b0;
        rst_n     = 1'b1;
        n = 0;
        while (gpio_hold === 1'b1 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        check(16'(n >= HOLD - 1 && n <= HOLD + 4), 16'h1);
        n = 0;
        while (prg_wait !== 1'b1 && master_active !== 1'b1 && n < 3000) begin
            @(negedge sys_clk);
            n++;
        end
        check(16'(n < 3000), 16'h1);
        repeat (12) @(negedge sys_clk);
    endtask : boot

    task automatic ser(input logic wr, input logic [7:0] a, input logic [7:0] d);
        ser_req = '{1'b1, wr, a, d};
        @(negedge sys_clk);
        ser_req = '0;
        @(negedge sys_clk);
        q = ser_rdata;
    endtask : ser

    task automatic cmd(input cmd_t c, input logic [1:0] exp);
        int a;
        int r;
        a = acc_cnt;
        r = rej_cnt;
        cmd_valid = 1'b1;
        cmd_code  = c;
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        cmd_code  = CMD_NONE;
        repeat (3) @(negedge sys_clk);
        check(16'((acc_cnt - a) * 256 + (rej_cnt - r)), {7'h00, exp[1], 7'h00, exp[0]});
    endtask : cmd

    initial begin
        rst_n = 1'b0; gpio_pin = 7'h00; ser_req = '0; cmd_valid = 1'b0; cmd_code = CMD_NONE;
        lock_byte = 8'h00; dis_byte = 8'h00; ee_mode = 2'h0; order_bad = 1'b0;
        bad_count = 0; checked = 0; cycles = 0; acc_cnt = 0; rej_cnt = 0; prog_cnt = 0;
        srch_cnt = 0; prog_val = 2'h0;
        for (int i = 0; i < 5; i++) begin
            s0 = srch_cnt;
            boot(lk_tab[i], 8'h00, 7'h00, 2'h0);
            check({master_active, xo_enable, prg_wait}, {act_tab[i], act_tab[i], !act_tab[i]});
            check(slave_rst_n, act_tab[i] ? 16'h01FF : 16'h0000);
            check({order_bad, ee_read_done, ee_error, ser_i2c, ser_slave_en}, 5'h09);
            check(16'(srch_cnt - s0), 16'h0);
            if (i == 0) cmd(CMD_ESCAPE, 2'b10);
            if (i == 0) check(prg_wait, 16'h1);
        end
        check(gpio_mode, 16'h003C);
        for (int a = 0; a < 6; a++) begin
            ser(1'b0, 8'(a), 8'h00);
            check(q, a == 0 ? 8'h04 : a == 1 ? 8'h00 : a == 2 ? 8'h00 :
                  a == 3 ? 8'h3C : 8'(a) ^ 8'hA5);
        end
        ser(1'b0, 8'hFF, 8'h00);
        check(q, 16'h0000);
        ser(1'b1, 8'hFF, 8'h03);
        ser(1'b1, 8'h03, 8'h77);
        ser(1'b0, 8'hFF, 8'h00);
        check({q, ser_page}, 16'h0303);
        ser(1'b1, 8'hFF, 8'h00);
        ser(1'b0, 8'h03, 8'h00);
        check(q, 16'h003C);
        cmd(CMD_ESCAPE, 2'b01);
        cmd(CMD_NONE, 2'b00);
        ser(1'b1, 8'h03, 8'h5A);
        repeat (300) @(negedge sys_clk);
        check(gpio_mode, 16'h003C);
        s0 = prog_cnt;
        cmd(CMD_LOCK_STORE, 2'b10);
        check({8'(prog_cnt - s0), 6'h00, prog_val}, 16'h0102);
        cmd(CMD_COPY_LIVE, 2'b10);
        repeat (300) @(negedge sys_clk);
        check({gpio_mode, 7'h00, prg_wait}, 16'h5A01);
        // Host releases the slaves by hand and would then program each one
        cmd(CMD_PROCEED, 2'b10);
        check({master_active, xo_enable, slave_rst_n}, 11'h7FF);
        cmd(CMD_COPY_LIVE, 2'b01);
        check({master_active, prg_wait}, 16'h2);
        cmd(CMD_ESCAPE, 2'b10);
        check(prg_wait, 16'h1);
        for (int m = 0; m < 3; m++) begin
            s0 = srch_cnt;
            boot(8'h07, 8'h00, 7'h40, 2'(m));
            check(16'(srch_cnt > s0), 16'h1);
            check({ee_read_done, ee_error, ser_slave_en}, {1'b1, m != 0, 1'b1});
            check({gpio_mode, 7'h00, ser_i2c}, m == 0 ? 16'hA500 : 16'h3C01);
            ser(1'b0, 8'h04, 8'h00);
            check(q, 16'h00A1);
            if (m == 0) ser(1'b0, 8'h03, 8'h00);
            if (m == 0) check(q, 16'h00A5);
        end
        s0 = srch_cnt;
        boot(8'h07, 8'h01, 7'h41, 2'h0);
        check({16'(srch_cnt - s0)}, 16'h0);
        check({ee_read_done, ee_error, ser_i2c}, 16'h5);
        finish_test();
    end
endmodule : testbench
